// [hdl/spe_pin_enable.sv]
`timescale 1ns/10ps
module spe_pin_enable (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // Device reset pin and product term
   input wire logic dev_resetn_in,
   input wire logic scan_pin_select_term_in,
   // Host register port
   input wire logic reg_sel_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // Port pins
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe_out,
   // General I/O side
   input wire logic [3:0] gpio_out_in,
   input wire logic [3:0] gpio_oe_in,
   output logic [3:0] gpio_in_out,
   // Status
   output logic port_on_out,
   output logic tdo_active_out
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [3:0] pins;
   logic dev_rst;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync1 <= 5'h1f;
         sync2 <= 5'h1f;
      end else begin
         sync1 <= {dev_resetn_in, pin_in};
         sync2 <= sync1;
      end
   end

   assign pins = sync2[3:0];
   assign dev_rst = !sync2[4];

   // ************************************************************
   // State
   // ************************************************************
   spe_store_if st ();

   spe_pkg::spe_state_e state;
   spe_pkg::spe_state_e next_state;
   logic run_enable;
   logic next_run_enable;
   logic tck_q;
   logic [spe_pkg::SPE_CNT_W-1:0] cnt;
   logic [spe_pkg::SPE_CNT_W-1:0] next_cnt;
   logic [spe_pkg::SPE_CMD_W-1:0] shift;
   logic [spe_pkg::SPE_CMD_W-1:0] next_shift;
   logic [spe_pkg::SPE_DATA_W-1:0] tdo_sh;
   logic [spe_pkg::SPE_DATA_W-1:0] next_tdo_sh;
   logic tdo_active;
   logic next_tdo_active;
   logic [7:0] next_rdata;
   logic [3:0] next_pin_out;
   logic [3:0] next_pin_oe;
   logic port_on;
   logic block;
   logic tck_rise;
   logic [spe_pkg::SPE_OP_W-1:0] op;

   assign port_on = st.dedicate | run_enable | scan_pin_select_term_in;
   // The nonvolatile dedication shields the port from device reset
   assign block = dev_rst & ~st.dedicate;
   assign tck_rise = pins[spe_pkg::SPE_PIN_TCK] & ~tck_q;
   assign op = shift[spe_pkg::SPE_OP_LSB +: spe_pkg::SPE_OP_W];

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shift = shift;
      next_tdo_sh = tdo_sh;
      next_tdo_active = tdo_active;
      st.erase = 1'b0;
      st.prog = 1'b0;
      st.cfg_wr = 1'b0;
      st.cfg_val = shift[0];
      st.addr = shift[spe_pkg::SPE_ADDR_LSB +: spe_pkg::SPE_ADDR_W];
      st.wdata = shift[spe_pkg::SPE_DATA_W-1:0];

      // Host register; bits above bit zero are dropped on write
      next_run_enable = run_enable;
      if (reg_sel_in && reg_wr_in && (reg_addr_in == spe_pkg::SPE_ENABLE_OFFSET)) begin
         next_run_enable = reg_wdata_in[spe_pkg::SPE_ENABLE_BIT];
      end
      if (dev_rst) begin
         next_run_enable = spe_pkg::SPE_ENABLE_RESET;
      end
      next_rdata = reg_rdata_out;
      if (reg_sel_in && reg_rd_in) begin
         next_rdata = 8'h00;
         if (reg_addr_in == spe_pkg::SPE_ENABLE_OFFSET) begin
            next_rdata[spe_pkg::SPE_ENABLE_BIT] = run_enable;
         end
      end

      // Serial engine: abort to idle when blocked or pins released
      if (!port_on || block) begin
         next_state = spe_pkg::SPE_IDLE;
         next_cnt = '0;
         next_tdo_active = 1'b0;
      end else begin
         unique case (state)
            spe_pkg::SPE_IDLE: begin
               if (tck_rise && !pins[spe_pkg::SPE_PIN_TMS]) begin
                  next_state = spe_pkg::SPE_SHIFT;
                  next_cnt = 5'h01;
                  next_shift = {shift[spe_pkg::SPE_CMD_W-2:0], pins[spe_pkg::SPE_PIN_TDI]};
                  next_tdo_sh = {tdo_sh[spe_pkg::SPE_DATA_W-2:0], 1'b0};
               end
            end
            spe_pkg::SPE_SHIFT: begin
               if (tck_rise && pins[spe_pkg::SPE_PIN_TMS]) begin
                  next_state = (cnt == spe_pkg::SPE_CMD_BITS) ? spe_pkg::SPE_EXEC
                                                             : spe_pkg::SPE_IDLE;
               end else if (tck_rise) begin
                  // Count saturates so an overlong word is refused
                  if (cnt != spe_pkg::SPE_CMD_BITS + 5'h01) begin
                     next_cnt = cnt + 5'h01;
                  end
                  next_shift = {shift[spe_pkg::SPE_CMD_W-2:0], pins[spe_pkg::SPE_PIN_TDI]};
                  next_tdo_sh = {tdo_sh[spe_pkg::SPE_DATA_W-2:0], 1'b0};
               end
            end
            spe_pkg::SPE_EXEC: begin
               next_state = spe_pkg::SPE_IDLE;
               next_cnt = '0;
               unique case (op)
                  spe_pkg::SPE_OP_ENABLE: next_tdo_active = 1'b1;
                  spe_pkg::SPE_OP_DISABLE: next_tdo_active = 1'b0;
                  spe_pkg::SPE_OP_ERASE: st.erase = 1'b1;
                  spe_pkg::SPE_OP_PROG: st.prog = 1'b1;
                  spe_pkg::SPE_OP_READ: next_tdo_sh = st.rdata;
                  spe_pkg::SPE_OP_CFG: st.cfg_wr = 1'b1;
                  default: next_tdo_sh = tdo_sh;
               endcase
            end
            default: next_state = spe_pkg::SPE_IDLE;
         endcase
      end

      // Pin muxing: port claims all four, TDO drives only once enabled
      for (int i = 0; i < spe_pkg::SPE_PIN_N; i++) begin
         if (port_on) begin
            next_pin_out[i] = (i == spe_pkg::SPE_PIN_TDO) && tdo_sh[spe_pkg::SPE_DATA_W-1];
            next_pin_oe[i] = (i == spe_pkg::SPE_PIN_TDO) && next_tdo_active;
         end else begin
            next_pin_out[i] = gpio_out_in[i];
            next_pin_oe[i] = gpio_oe_in[i];
         end
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= spe_pkg::SPE_IDLE;
         run_enable <= spe_pkg::SPE_ENABLE_RESET;
         tck_q <= 1'b1;
         cnt <= '0;
         shift <= '0;
         tdo_sh <= '0;
         tdo_active <= 1'b0;
         reg_rdata_out <= 8'h00;
         pin_out <= 4'h0;
         pin_oe_out <= 4'h0;
         gpio_in_out <= 4'h0;
      end else begin
         state <= next_state;
         run_enable <= next_run_enable;
         tck_q <= pins[spe_pkg::SPE_PIN_TCK];
         cnt <= next_cnt;
         shift <= next_shift;
         tdo_sh <= next_tdo_sh;
         tdo_active <= next_tdo_active;
         reg_rdata_out <= next_rdata;
         pin_out <= next_pin_out;
         pin_oe_out <= next_pin_oe;
         gpio_in_out <= pins;
      end
   end

   assign port_on_out = port_on;
   assign tdo_active_out = tdo_active;

   spe_cfg_store u_store (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .st(st.store)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   property p_reset_clears;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      dev_rst |=> !run_enable ##1 (reg_rdata_out[0] == 1'b0 || !$past(reg_rd_in));
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("Enable bit survived reset");

   property p_write_bit0;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_sel_in && reg_wr_in && reg_addr_in == spe_pkg::SPE_ENABLE_OFFSET && !dev_rst)
      |=> run_enable == $past(reg_wdata_in[0]);
   endproperty
   a_write_bit0: assert property (p_write_bit0) else $error("Enable bit not written");

   property p_readback;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_sel_in && reg_rd_in && reg_addr_in == spe_pkg::SPE_ENABLE_OFFSET)
      |=> reg_rdata_out == {7'h00, $past(run_enable)};
   endproperty
   a_readback: assert property (p_readback) else $error("Register readback wrong");

   property p_pins_input;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      port_on |=> pin_oe_out[2:0] == 3'h0;
   endproperty
   a_pins_input: assert property (p_pins_input) else $error("Port drove an input pin");

   property p_tdo_quiet;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      (port_on && !tdo_active && state != spe_pkg::SPE_EXEC) |=> !pin_oe_out[3];
   endproperty
   a_tdo_quiet: assert property (p_tdo_quiet) else $error("TDO driven before enable");

   sequence s_enable_cmd;
      state == spe_pkg::SPE_EXEC && op == spe_pkg::SPE_OP_ENABLE && port_on && !block;
   endsequence
   property p_enable_cmd;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      s_enable_cmd |=> tdo_active && pin_oe_out[3];
   endproperty
   a_enable_cmd: assert property (p_enable_cmd) else $error("Enable command ignored");

   property p_abort;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      block |=> state == spe_pkg::SPE_IDLE && !tdo_active;
   endproperty
   a_abort: assert property (p_abort) else $error("Reset did not abort port");

   sequence s_dedicated_shift;
      dev_rst && st.dedicate && state == spe_pkg::SPE_SHIFT && tck_rise
      && !pins[spe_pkg::SPE_PIN_TMS];
   endsequence
   property p_no_abort;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      s_dedicated_shift |=> state == spe_pkg::SPE_SHIFT && shift[0] == $past(pins[2]);
   endproperty
   a_no_abort: assert property (p_no_abort) else $error("Reset disturbed dedicated port");
endmodule

// [pkg/spe_pkg.sv]
package spe_pkg;
   // ************************************************************
   // Host register
   // ************************************************************
   localparam int SPE_DATA_W = 8;
   localparam logic [7:0] SPE_ENABLE_OFFSET = 8'hc7;
   localparam int SPE_ENABLE_BIT = 0;
   localparam logic SPE_ENABLE_RESET = 1'b0;

   // ************************************************************
   // Port pins, index into the four-pin group
   // ************************************************************
   localparam int SPE_PIN_N = 4;
   localparam int SPE_PIN_TMS = 0;
   localparam int SPE_PIN_TCK = 1;
   localparam int SPE_PIN_TDI = 2;
   localparam int SPE_PIN_TDO = 3;

   // ************************************************************
   // Serial command word: opcode, array address, data
   // ************************************************************
   localparam int SPE_CMD_W = 16;
   localparam int SPE_CNT_W = 5;
   localparam logic [4:0] SPE_CMD_BITS = 5'h10;
   localparam int SPE_OP_LSB = 12;
   localparam int SPE_OP_W = 4;
   localparam int SPE_ADDR_LSB = 8;
   localparam logic [3:0] SPE_OP_ENABLE = 4'h1;
   localparam logic [3:0] SPE_OP_DISABLE = 4'h2;
   localparam logic [3:0] SPE_OP_ERASE = 4'h3;
   localparam logic [3:0] SPE_OP_PROG = 4'h4;
   localparam logic [3:0] SPE_OP_READ = 4'h5;
   localparam logic [3:0] SPE_OP_CFG = 4'h6;

   // ************************************************************
   // Nonvolatile store and its blank state
   // ************************************************************
   localparam int SPE_ARRAY_DEPTH = 4;
   localparam int SPE_ADDR_W = 2;
   localparam logic [7:0] SPE_BLANK_WORD = 8'hff;
   localparam logic SPE_BLANK_CFG = 1'b0;

   typedef enum logic [1:0] {
      SPE_IDLE = 2'b00,
      SPE_SHIFT = 2'b01,
      SPE_EXEC = 2'b11
   } spe_state_e;
endpackage

// [pkg/spe_store_if.sv]
`timescale 1ns/10ps
interface spe_store_if;
   logic erase;
   logic prog;
   logic cfg_wr;
   logic cfg_val;
   logic [spe_pkg::SPE_ADDR_W-1:0] addr;
   logic [spe_pkg::SPE_DATA_W-1:0] wdata;
   logic [spe_pkg::SPE_DATA_W-1:0] rdata;
   logic dedicate;

   modport ctl (output erase, prog, cfg_wr, cfg_val, addr, wdata, input rdata, dedicate);
   modport store (input erase, prog, cfg_wr, cfg_val, addr, wdata, output rdata, dedicate);
endinterface

// [hdl/spe_cfg_store.sv]
`timescale 1ns/10ps
module spe_cfg_store (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // Command side
   spe_store_if.store st
);
   logic [spe_pkg::SPE_DATA_W-1:0] mem [spe_pkg::SPE_ARRAY_DEPTH];
   logic [spe_pkg::SPE_DATA_W-1:0] next_mem [spe_pkg::SPE_ARRAY_DEPTH];
   logic dedicate;
   logic next_dedicate;

   // ************************************************************
   // Array and configuration bit
   // ************************************************************
   // Programming can only clear bits; only erase brings them back to one
   always_comb begin
      for (int i = 0; i < spe_pkg::SPE_ARRAY_DEPTH; i++) begin
         next_mem[i] = mem[i];
         if (st.erase) begin
            next_mem[i] = spe_pkg::SPE_BLANK_WORD;
         end else if (st.prog && (st.addr == i[spe_pkg::SPE_ADDR_W-1:0])) begin
            next_mem[i] = mem[i] & st.wdata;
         end
      end
      next_dedicate = dedicate;
      if (st.erase) begin
         next_dedicate = spe_pkg::SPE_BLANK_CFG;
      end else if (st.cfg_wr) begin
         next_dedicate = st.cfg_val;
      end
   end

   // Reset stands for the shipped blank part
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < spe_pkg::SPE_ARRAY_DEPTH; i++) begin
            mem[i] <= spe_pkg::SPE_BLANK_WORD;
         end
         dedicate <= spe_pkg::SPE_BLANK_CFG;
      end else begin
         mem <= next_mem;
         dedicate <= next_dedicate;
      end
   end

   assign st.rdata = mem[st.addr];
   assign st.dedicate = dedicate;

   property p_erase_blank;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      st.erase |=> (mem[0] == spe_pkg::SPE_BLANK_WORD) && (st.rdata == spe_pkg::SPE_BLANK_WORD);
   endproperty
   a_erase_blank: assert property (p_erase_blank) else $error("Erase left a zero bit");

   property p_erase_cfg;
      @(posedge ref_clk_in) disable iff (!resetn_in)
      st.erase |=> !st.dedicate;
   endproperty
   a_erase_cfg: assert property (p_erase_cfg) else $error("Erase left config bit set");
endmodule

// [testbench/spe_scan_ctrl.sv]
`timescale 1ns/10ps
module spe_scan_ctrl (
   // Reference clock
   input wire logic clk_in,
   // Serial data coming back from the device
   input wire logic tdo_in,
   // Serial drive towards the device
   output logic tms_out,
   output logic tck_out,
   output logic tdi_out
);
   // Reference clocks per step, three steps per bit; at least 3 so each returned TDO bit settles before it is sampled
   int gap = 5;

   initial begin
      tms_out = 1'b1;
      tck_out = 1'b0;
      tdi_out = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // ************************************************************
   // One 16-bit frame, bit 15 first; TCK stands low between frames
   // ************************************************************
   task automatic send_word(input logic [15:0] w, output logic [15:0] got);
      for (int i = 15; i >= 0; i--) begin
         wait_clk(gap);
         got[i] = tdo_in;
         tms_out <= 1'b0;
         tdi_out <= w[i];
         wait_clk(gap);
         tck_out <= 1'b1;
         wait_clk(gap);
         tck_out <= 1'b0;
      end
      wait_clk(gap);
      tms_out <= 1'b1;
      // Released data line toggles so a stale level is never mistaken
      tdi_out <= ~tdi_out;
      wait_clk(gap);
      tck_out <= 1'b1;
      wait_clk(gap);
      tck_out <= 1'b0;
      wait_clk(gap);
   endtask
endmodule

// [testbench/scan_port_pin_enable_tb.sv]
`timescale 1ns/10ps
module scan_port_pin_enable_tb;
   typedef struct {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp_rd;
      logic exp_on;
   } spe_row_s;

   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic dev_resetn_in = 1'b1;
   logic term = 1'b0;
   logic sel = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [3:0] gpio_o = 4'h0;
   logic [3:0] gpio_e = 4'h0;
   logic [3:0] gpio_i;
   logic [7:0] rdata;
   logic [3:0] pin_out;
   logic [3:0] pin_oe;
   logic port_on;
   logic tdo_act;
   logic tms, tck, tdi, tdo;
   logic [15:0] got;
   logic [7:0] rv;
   int errors = 0;
   int n_compared = 0;
   spe_row_s rows [4];

   // No pull-up on the serial output: undriven reads low
   assign tdo = pin_oe[3] ? pin_out[3] : 1'b0;

   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   spe_pin_enable dut_u (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .dev_resetn_in(dev_resetn_in),
      .scan_pin_select_term_in(term),
      .reg_sel_in(sel),
      .reg_wr_in(wr),
      .reg_rd_in(rd),
      .reg_addr_in(addr),
      .reg_wdata_in(wdata),
      .reg_rdata_out(rdata),
      .pin_in({tdo, tdi, tck, tms}),
      .pin_out(pin_out),
      .pin_oe_out(pin_oe),
      .gpio_out_in(gpio_o),
      .gpio_oe_in(gpio_e),
      .gpio_in_out(gpio_i),
      .port_on_out(port_on),
      .tdo_active_out(tdo_act)
   );

   spe_scan_ctrl scan_u (
      .clk_in(ref_clk_in),
      .tdo_in(tdo),
      .tms_out(tms),
      .tck_out(tck),
      .tdi_out(tdi)
   );

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic reg_acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      sel <= 1'b1;
      wr <= w;
      rd <= ~w;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_in);
      sel <= 1'b0;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge ref_clk_in);
      #1 rv = rdata;
   endtask

   task automatic cmd(input logic [3:0] op, input logic [1:0] a, input logic [7:0] d);
      scan_u.send_word({op, 2'b00, a, d}, got);
   endtask

   task automatic dev_reset(input logic v);
      @(posedge ref_clk_in);
      dev_resetn_in <= v;
      repeat (6) @(posedge ref_clk_in);
   endtask

   // Bounded wait for the serial output enable to reach a level
   task automatic wait_tdo(input logic exp);
      for (int i = 0; i < 40 && tdo_act !== exp; i++)
         @(posedge ref_clk_in);
      if (tdo_act !== exp) begin
         check("tdo_wait", tdo_act, exp);
         results();
      end
   endtask

   initial begin
      rows[0] = '{8'hc7, 8'h01, 8'h01, 1'b1};
      rows[1] = '{8'hc7, 8'h00, 8'h00, 1'b0};
      rows[2] = '{8'hc7, 8'h01, 8'h01, 1'b1};
      rows[3] = '{8'hc6, 8'h00, 8'h01, 1'b1};
      repeat (12) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      reg_acc(1'b0, 8'hc7, 8'h00);
      check("enable_after_reset", rv, 8'h00);
      check("port_blank", {7'h0, port_on}, 8'h00);
      // Port off: the pins follow the general I/O side
      @(posedge ref_clk_in);
      gpio_o <= 4'h5;
      gpio_e <= 4'ha;
      repeat (3) @(posedge ref_clk_in);
      check("gpio_drive", {pin_oe, pin_out}, 8'ha5);
      check("gpio_sense", {4'h0, gpio_i}, 8'h01);
      gpio_o <= 4'h0;
      gpio_e <= 4'h0;
      foreach (rows[i]) begin
         reg_acc(1'b1, rows[i].addr, rows[i].wdata);
         reg_acc(1'b0, 8'hc7, 8'h00);
         check("enable_read", rv, rows[i].exp_rd);
         check("port_on", {7'h0, port_on}, {7'h0, rows[i].exp_on});
      end
      reg_acc(1'b0, 8'h12, 8'h00);
      check("unmapped_read", rv, 8'h00);
      check("pins_input", {4'h0, pin_oe}, 8'h00);
      cmd(spe_pkg::SPE_OP_ENABLE, 2'h0, 8'h00);
      wait_tdo(1'b1);
      check("tdo_drive", {4'h0, pin_oe}, 8'h08);
      cmd(spe_pkg::SPE_OP_READ, 2'h1, 8'h00);
      cmd(spe_pkg::SPE_OP_PROG, 2'h1, 8'h5a);
      check("blank_word", got[15:8], 8'hff);
      scan_u.gap = 9;
      cmd(spe_pkg::SPE_OP_READ, 2'h1, 8'h00);
      scan_u.gap = 5;
      cmd(spe_pkg::SPE_OP_ERASE, 2'h0, 8'h00);
      check("prog_word", got[15:8], 8'h5a);
      cmd(spe_pkg::SPE_OP_READ, 2'h1, 8'h00);
      cmd(spe_pkg::SPE_OP_DISABLE, 2'h0, 8'h00);
      check("erased_word", got[15:8], 8'hff);
      wait_tdo(1'b0);
      // Port held on by the product term only: device reset blocks and aborts
      reg_acc(1'b1, 8'hc7, 8'h00);
      @(posedge ref_clk_in);
      term <= 1'b1;
      cmd(spe_pkg::SPE_OP_ENABLE, 2'h0, 8'h00);
      wait_tdo(1'b1);
      dev_reset(1'b0);
      check("abort", {7'h0, tdo_act}, 8'h00);
      cmd(spe_pkg::SPE_OP_ENABLE, 2'h0, 8'h00);
      check("blocked", {7'h0, tdo_act}, 8'h00);
      dev_reset(1'b1);
      fork
         cmd(spe_pkg::SPE_OP_ENABLE, 2'h0, 8'h00);
         begin
            repeat (80) @(posedge ref_clk_in);
            dev_reset(1'b0);
            dev_reset(1'b1);
         end
      join
      check("mid_abort", {7'h0, tdo_act}, 8'h00);
      term <= 1'b0;
      // Register enable, then dedicate: device reset no longer blocks the port but still clears the register enable
      reg_acc(1'b1, 8'hc7, 8'h01);
      cmd(spe_pkg::SPE_OP_CFG, 2'h0, 8'h01);
      cmd(spe_pkg::SPE_OP_ENABLE, 2'h0, 8'h00);
      wait_tdo(1'b1);
      dev_reset(1'b0);
      check("dedicated_hold", {6'h0, port_on, tdo_act}, 8'h03);
      cmd(spe_pkg::SPE_OP_DISABLE, 2'h0, 8'h00);
      check("dedicated_run", {7'h0, tdo_act}, 8'h00);
      dev_reset(1'b1);
      reg_acc(1'b0, 8'hc7, 8'h00);
      check("enable_cleared", rv, 8'h00);
      cmd(spe_pkg::SPE_OP_ERASE, 2'h0, 8'h00);
      check("cfg_erased", {7'h0, port_on}, 8'h00);
      results();
   end
endmodule
